// ---- rtl/ccd_top.v ----
// Purpose: Channel clock dividers 0..3 behind an APB register slave
// Assumes: clk is 125 MHz; divider input is a pulse train derived from clk
// Notes: Register index * 4 is the APB byte address
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ccd_defines.vh"
module ccd_top #(
  parameter ADDR_W = 14
) (
  input wire clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire ext_clk_in,
  input wire src_is_vco,
  input wire vco_div_used,
  output wire [3:0] ch_out,
  output wire [1:0] ch_b_out
);
  //----------------------------------------------------------
  // Register file
  //----------------------------------------------------------
  reg [7:0] d0_cnt_r, d0_byp_r, d0_fix_r;
  reg [7:0] d1_cnt_r, d1_byp_r, d1_fix_r;
  reg [7:0] d2_cnt1_r, d2_cnt2_r, d2_byp_r, d2_fix_r;
  reg [7:0] d3_cnt1_r, d3_cnt2_r, d3_byp_r, d3_fix_r;
  reg [7:0] vco_r;
  reg sync_r;
  reg ext_m_r, ext_s_r, ext_d_r;
  reg [2:0] vdiv_cnt_r;
  reg vdiv_lvl_r;
  reg vdiv_tick_r;
  wire [11:0] idx;
  wire wr_en;
  wire rd_en;
  wire hit;
  wire [2:0] vco_ratio;
  wire src_tick;
  wire src_level;
  wire tick;
  wire in_level;
  wire [5:0] st_level;
  wire [5:0] st_tick;
  reg [7:0] rd_byte;
  // Word index from byte address
  assign idx = paddr[13:2];
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  // Decode valid offsets
  function is_mapped;
    input [11:0] i;
    begin
      case (i)
        `CCD_IDX_D0_CNT, `CCD_IDX_D0_BYP, `CCD_IDX_D0_FIX,
        `CCD_IDX_D1_CNT, `CCD_IDX_D1_BYP, `CCD_IDX_D1_FIX,
        `CCD_IDX_D2_CNT1, `CCD_IDX_D2_CNT2, `CCD_IDX_D2_BYP, `CCD_IDX_D2_FIX,
        `CCD_IDX_D3_CNT1, `CCD_IDX_D3_CNT2, `CCD_IDX_D3_BYP, `CCD_IDX_D3_FIX,
        `CCD_IDX_VCO_DIV, `CCD_IDX_SYNC: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction
  assign hit = is_mapped(idx);
  // Register writes; sync is a one-cycle pulse
  always @(posedge clk) begin
    if (!rstn) begin
      d0_cnt_r <= `CCD_RST_CNT;
      d0_byp_r <= `CCD_RST_BYP;
      d0_fix_r <= `CCD_RST_FIX;
      d1_cnt_r <= `CCD_RST_CNT;
      d1_byp_r <= `CCD_RST_BYP;
      d1_fix_r <= `CCD_RST_FIX;
      d2_cnt1_r <= `CCD_RST_CNT;
      d2_cnt2_r <= `CCD_RST_CNT;
      d2_byp_r <= `CCD_RST_BYP;
      d2_fix_r <= `CCD_RST_FIX;
      d3_cnt1_r <= `CCD_RST_CNT;
      d3_cnt2_r <= `CCD_RST_CNT;
      d3_byp_r <= `CCD_RST_BYP;
      d3_fix_r <= `CCD_RST_FIX;
      vco_r <= `CCD_RST_VCO;
      sync_r <= 1'b0;
    end else begin
      sync_r <= wr_en & (idx == `CCD_IDX_SYNC) & pwdata[`CCD_BIT_SYNC];
      if (wr_en) begin
        case (idx)
          `CCD_IDX_D0_CNT: d0_cnt_r <= pwdata[7:0];
          `CCD_IDX_D0_BYP: d0_byp_r <= pwdata[7:0];
          `CCD_IDX_D0_FIX: d0_fix_r <= pwdata[7:0];
          `CCD_IDX_D1_CNT: d1_cnt_r <= pwdata[7:0];
          `CCD_IDX_D1_BYP: d1_byp_r <= pwdata[7:0];
          `CCD_IDX_D1_FIX: d1_fix_r <= pwdata[7:0];
          `CCD_IDX_D2_CNT1: d2_cnt1_r <= pwdata[7:0];
          `CCD_IDX_D2_CNT2: d2_cnt2_r <= pwdata[7:0];
          `CCD_IDX_D2_BYP: d2_byp_r <= pwdata[7:0];
          `CCD_IDX_D2_FIX: d2_fix_r <= pwdata[7:0];
          `CCD_IDX_D3_CNT1: d3_cnt1_r <= pwdata[7:0];
          `CCD_IDX_D3_CNT2: d3_cnt2_r <= pwdata[7:0];
          `CCD_IDX_D3_BYP: d3_byp_r <= pwdata[7:0];
          `CCD_IDX_D3_FIX: d3_fix_r <= pwdata[7:0];
          `CCD_IDX_VCO_DIV: vco_r <= {5'h00, pwdata[2:0]};
          default: ;
        endcase
      end
    end
  end
  // Read mux
  always @* begin
    case (idx)
      `CCD_IDX_D0_CNT: rd_byte = d0_cnt_r;
      `CCD_IDX_D0_BYP: rd_byte = d0_byp_r;
      `CCD_IDX_D0_FIX: rd_byte = d0_fix_r;
      `CCD_IDX_D1_CNT: rd_byte = d1_cnt_r;
      `CCD_IDX_D1_BYP: rd_byte = d1_byp_r;
      `CCD_IDX_D1_FIX: rd_byte = d1_fix_r;
      `CCD_IDX_D2_CNT1: rd_byte = d2_cnt1_r;
      `CCD_IDX_D2_CNT2: rd_byte = d2_cnt2_r;
      `CCD_IDX_D2_BYP: rd_byte = d2_byp_r;
      `CCD_IDX_D2_FIX: rd_byte = d2_fix_r;
      `CCD_IDX_D3_CNT1: rd_byte = d3_cnt1_r;
      `CCD_IDX_D3_CNT2: rd_byte = d3_cnt2_r;
      `CCD_IDX_D3_BYP: rd_byte = d3_byp_r;
      `CCD_IDX_D3_FIX: rd_byte = d3_fix_r;
      `CCD_IDX_VCO_DIV: rd_byte = vco_r;
      `CCD_IDX_SYNC: rd_byte = {2'h0, st_level};
      default: rd_byte = 8'h00;
    endcase
  end
  // Read data registered in setup phase, valid in access phase
  always @(posedge clk) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= {24'h000000, rd_byte};
    end
  end
  //----------------------------------------------------------
  // Divider input source
  //----------------------------------------------------------
  // External clock passes two flip-flops before use
  always @(posedge clk) begin
    if (!rstn) begin
      ext_m_r <= 1'b0;
      ext_s_r <= 1'b0;
      ext_d_r <= 1'b0;
    end else begin
      ext_m_r <= ext_clk_in;
      ext_s_r <= ext_m_r;
      ext_d_r <= ext_s_r;
    end
  end
  // Ratio clamped to 2..6
  assign vco_ratio = (vco_r[2:0] < 3'h2) ? 3'h2 : (vco_r[2:0] > 3'h6) ? 3'h6 : vco_r[2:0];
  // Pre-divider: source is ext edge or free clk when VCO selected
  assign src_tick = src_is_vco ? 1'b1 : (ext_s_r & ~ext_d_r);
  assign src_level = src_is_vco ? 1'b1 : ext_s_r;
  always @(posedge clk) begin
    if (!rstn) begin
      vdiv_cnt_r <= 3'h0;
      vdiv_lvl_r <= 1'b0;
      vdiv_tick_r <= 1'b0;
    end else begin
      vdiv_tick_r <= 1'b0;
      if (src_tick) begin
        if (vdiv_cnt_r >= vco_ratio - 3'h1) begin
          vdiv_cnt_r <= 3'h0;
          vdiv_tick_r <= 1'b1;
        end else begin
          vdiv_cnt_r <= vdiv_cnt_r + 3'h1;
        end
        vdiv_lvl_r <= (vdiv_cnt_r < {1'b0, vco_ratio[2:1]}) ? 1'b0 : 1'b1;
      end
    end
  end
  // Routed clock feeding every channel divider
  assign tick = vco_div_used ? vdiv_tick_r : src_tick;
  assign in_level = vco_div_used ? vdiv_lvl_r : src_level;
  //----------------------------------------------------------
  // Channel dividers
  //----------------------------------------------------------
  // Stage 0: ch0, 1: ch1, 2/3: ch2 cascade, 4/5: ch3 cascade
  ccd_stage u_s0 (.clk(clk), .rstn(rstn), .tick(tick), .sync(sync_r),
    .low_cnt(d0_cnt_r[7:4]), .high_cnt(d0_cnt_r[3:0]), .bypass(d0_byp_r[`CCD_BIT_BYPASS]),
    .fix_dis(d0_fix_r[`CCD_BIT_FIX_DIS]), .start_high(d0_byp_r[`CCD_BIT_START_HIGH]),
    .phase_delay_field(d0_byp_r[3:0]), .in_level(in_level),
    .out_level(st_level[0]), .out_tick(st_tick[0]));
  ccd_stage u_s1 (.clk(clk), .rstn(rstn), .tick(tick), .sync(sync_r),
    .low_cnt(d1_cnt_r[7:4]), .high_cnt(d1_cnt_r[3:0]), .bypass(d1_byp_r[`CCD_BIT_BYPASS]),
    .fix_dis(d1_fix_r[`CCD_BIT_FIX_DIS]), .start_high(d1_byp_r[`CCD_BIT_START_HIGH]),
    .phase_delay_field(d1_byp_r[3:0]), .in_level(in_level),
    .out_level(st_level[1]), .out_tick(st_tick[1]));
  ccd_stage u_s2 (.clk(clk), .rstn(rstn), .tick(tick), .sync(sync_r),
    .low_cnt(d2_cnt1_r[7:4]), .high_cnt(d2_cnt1_r[3:0]), .bypass(d2_byp_r[`CCD_BIT_BYP_S1]),
    .fix_dis(d2_fix_r[`CCD_BIT_FIX_DIS]), .start_high(1'b0), .phase_delay_field(4'h0),
    .in_level(in_level), .out_level(st_level[2]), .out_tick(st_tick[2]));
  // Second stage counts first stage output edges
  ccd_stage u_s3 (.clk(clk), .rstn(rstn), .tick(st_tick[2]), .sync(sync_r),
    .low_cnt(d2_cnt2_r[7:4]), .high_cnt(d2_cnt2_r[3:0]), .bypass(d2_byp_r[`CCD_BIT_BYP_S2]),
    .fix_dis(d2_fix_r[`CCD_BIT_FIX_DIS]), .start_high(1'b0), .phase_delay_field(4'h0),
    .in_level(st_level[2]), .out_level(st_level[3]), .out_tick());
  ccd_stage u_s4 (.clk(clk), .rstn(rstn), .tick(tick), .sync(sync_r),
    .low_cnt(d3_cnt1_r[7:4]), .high_cnt(d3_cnt1_r[3:0]), .bypass(d3_byp_r[`CCD_BIT_BYP_S1]),
    .fix_dis(d3_fix_r[`CCD_BIT_FIX_DIS]), .start_high(1'b0), .phase_delay_field(4'h0),
    .in_level(in_level), .out_level(st_level[4]), .out_tick(st_tick[4]));
  ccd_stage u_s5 (.clk(clk), .rstn(rstn), .tick(st_tick[4]), .sync(sync_r),
    .low_cnt(d3_cnt2_r[7:4]), .high_cnt(d3_cnt2_r[3:0]), .bypass(d3_byp_r[`CCD_BIT_BYP_S2]),
    .fix_dis(d3_fix_r[`CCD_BIT_FIX_DIS]), .start_high(1'b0), .phase_delay_field(4'h0),
    .in_level(st_level[4]), .out_level(st_level[5]), .out_tick());
  // Channel outputs; direct route passes the routed input level
  assign ch_out[0] = d0_fix_r[`CCD_BIT_DIRECT] ? in_level : st_level[0];
  assign ch_out[1] = d1_fix_r[`CCD_BIT_DIRECT] ? in_level : st_level[1];
  assign ch_out[2] = st_level[3];
  assign ch_out[3] = st_level[5];
  // B outputs gated off until enabled
  assign ch_b_out[0] = d2_byp_r[`CCD_BIT_B_EN] & st_level[3];
  assign ch_b_out[1] = d3_byp_r[`CCD_BIT_B_EN] & st_level[5];
endmodule
`default_nettype wire

// ---- rtl/ccd_defines.vh ----
// Purpose: Constants for the channel clock divider block
// Assumes: APB byte addresses are four times the register index
// Notes: Register indices kept as printed; byte address = index * 4
`ifndef CCD_DEFINES_VH
`define CCD_DEFINES_VH
// Register indices
`define CCD_IDX_D0_CNT 12'h190
`define CCD_IDX_D0_BYP 12'h191
`define CCD_IDX_D0_FIX 12'h192
`define CCD_IDX_D1_CNT 12'h196
`define CCD_IDX_D1_BYP 12'h197
`define CCD_IDX_D1_FIX 12'h198
`define CCD_IDX_D2_CNT1 12'h199
`define CCD_IDX_D2_CNT2 12'h19b
`define CCD_IDX_D2_BYP 12'h19c
`define CCD_IDX_D2_FIX 12'h19d
`define CCD_IDX_D3_CNT1 12'h19e
`define CCD_IDX_D3_CNT2 12'h1a0
`define CCD_IDX_D3_BYP 12'h1a1
`define CCD_IDX_D3_FIX 12'h1a2
`define CCD_IDX_VCO_DIV 12'h1e0
`define CCD_IDX_SYNC 12'h1e2
// Field positions
`define CCD_BIT_BYPASS 7
`define CCD_BIT_START_HIGH 4
`define CCD_BIT_FIX_DIS 0
`define CCD_BIT_DIRECT 1
`define CCD_BIT_BYP_S1 4
`define CCD_BIT_BYP_S2 5
`define CCD_BIT_B_EN 6
`define CCD_BIT_SYNC 0
// Reset values
`define CCD_RST_CNT 8'h00
`define CCD_RST_BYP 8'h00
`define CCD_RST_FIX 8'h00
`define CCD_RST_VCO 8'h00
// Delay code threshold
`define CCD_PHASE_SPLIT 5'h10
`endif

// ---- rtl/ccd_stage.v ----
// Purpose: One divide-by-1..32 stage with coarse phase delay; its duty fix flag reaches no output
// Assumes: Runs on the divider input enable of the system clock
// Notes: Output is a registered level plus a one-cycle tick flag
`timescale 1ns/1ns
`default_nettype none
`include "ccd_defines.vh"
module ccd_stage (
  input wire clk,
  input wire rstn,
  input wire tick,
  input wire sync,
  input wire [3:0] low_cnt,
  input wire [3:0] high_cnt,
  input wire bypass,
  input wire fix_dis,
  input wire start_high,
  input wire [3:0] phase_delay_field,
  input wire in_level,
  output reg out_level,
  output reg out_tick
);
  localparam ST_RUN = 2'h0;
  localparam ST_WAIT = 2'h1;
  reg [1:0] state_r;
  reg [4:0] cnt_r;
  reg [4:0] wait_r;
  reg [3:0] lat_low_r;
  reg [3:0] lat_high_r;
  reg half_r;
  reg neg_r;
  wire [4:0] code;
  wire [4:0] delay;
  wire fix_on;
  wire odd_fix;
  // Delay code: start-high weighted 16, field weights 8..1
  assign code = {start_high, phase_delay_field};
  assign delay = (code < `CCD_PHASE_SPLIT) ? code :
                 (code - `CCD_PHASE_SPLIT + {1'b0, low_cnt} + 5'h01);
  assign fix_on = ~fix_dis;
  assign odd_fix = fix_on & (lat_low_r == lat_high_r + 4'h1);
  // Counter, phase wait and output level
  always @(posedge clk) begin
    out_tick <= 1'b0;
    if (!rstn) begin
      state_r <= ST_RUN;
      cnt_r <= 5'h00;
      wait_r <= 5'h00;
      lat_low_r <= 4'h0;
      lat_high_r <= 4'h0;
      out_level <= 1'b0;
      half_r <= 1'b0;
    end else if (sync) begin
      // All counters restart together; new phase only here
      state_r <= (delay == 5'h00) ? ST_RUN : ST_WAIT;
      wait_r <= delay;
      cnt_r <= 5'h00;
      lat_low_r <= low_cnt;
      lat_high_r <= high_cnt;
      out_level <= 1'b0;
      half_r <= 1'b0;
    end else if (bypass) begin
      out_level <= in_level;
      out_tick <= tick;
    end else if (tick) begin
      case (state_r)
        ST_WAIT: begin
          wait_r <= wait_r - 5'h01;
          if (wait_r == 5'h01) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cnt_r == 5'h00) begin
            out_level <= 1'b1;
            out_tick <= 1'b1;
            half_r <= 1'b0;
          end
          // High for high+1, low for low+1 cycles
          if (cnt_r == {1'b0, lat_high_r} + 5'h01) begin
            out_level <= 1'b0;
            half_r <= odd_fix;
          end
          if (cnt_r == {1'b0, lat_high_r} + {1'b0, lat_low_r} + 5'h01) begin
            cnt_r <= 5'h00;
          end else begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end
  // Half-cycle flag sampled with the input level on the rising clock edge; neg_r feeds no output
  always @(posedge clk) begin
    if (!rstn) begin
      neg_r <= 1'b0;
    end else begin
      neg_r <= half_r & in_level;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/ccd_asserts.sv ----
// Purpose: Port-level checks for ccd_top
// Assumes: Bench issues a sync after every divider setup except the read-back writes and the final channel 0 phase write
// Notes: Shadow copies follow APB writes by the low byte of the register index
`timescale 1ns/1ns
`default_nettype none
module ccd_asserts #(
  parameter ADDR_W = 14
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic ext_clk_in,
  input wire logic src_is_vco,
  input wire logic vco_div_used,
  input wire logic [3:0] ch_out,
  input wire logic [1:0] ch_b_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [7:0] sh_r [0:255];
  logic lv_r;
  logic [5:0] run_r;
  logic [1:0] seen_r;
  logic [2:0] eq_r;
  logic [7:0] lc_r;
  logic [1:0] sd_r;
  wire [ADDR_W-3:0] idx = paddr[ADDR_W-1:2];
  wire wr = psel && penable && pwrite;
  wire syn = wr && idx == 12'h1e2 && pwdata[0];
  wire chg = ch_out[0] != lv_r;
  wire be2 = sh_r[8'h9c][6];
  wire md0 = src_is_vco && !vco_div_used && !sh_r[8'h91][7] && sh_r[8'h92][1:0] == 2'h1;
  wire same = sh_r[8'h90] == sh_r[8'h96] && sh_r[8'h91] == sh_r[8'h97] && sh_r[8'h92] == sh_r[8'h98];
  // ----------------------------------------
  // Shadows, run length, sync settling count
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < 256; i++) begin
        sh_r[i] <= 8'h00;
      end
    end else if (wr) begin
      sh_r[idx[7:0]] <= pwdata[7:0];
    end
  end
  // Run length of channel 0, invalidated by any write
  always @(posedge clk) begin
    lv_r <= ch_out[0];
    run_r <= chg ? 6'h01 : run_r + {5'h00, run_r != 6'h3f};
    // Counts only act at sync; ignore edges cut by the restart
    sd_r <= {sd_r[0], syn};
    if (syn) begin
      lc_r <= sh_r[8'h90];
    end
    if (!rstn) begin
      lc_r <= 8'h00;
      sd_r <= 2'h0;
    end
    if (!rstn || wr || sd_r != 2'h0) begin
      seen_r <= 2'h0;
    end else if (chg && seen_r != 2'h3) begin
      seen_r <= seen_r + 2'h1;
    end
    if (!rstn || (wr && !syn)) begin
      eq_r <= 3'h0;
    end else if (syn) begin
      eq_r <= {2'h0, same};
    end else if (eq_r != 3'h0 && eq_r != 3'h6) begin
      eq_r <= eq_r + 3'h1;
    end
  end
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_rd;
    psel && penable && !pwrite;
  endsequence
  a_ready_high: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  a_err_unmapped: assert property (s_acc ##0 idx == 12'h000 |-> pslverr)
    else $error("no error on unmapped access");
  a_read_upper: assert property (s_rd |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_read_back: assert property (s_rd ##0 idx == 12'h190 |-> prdata[7:0] == sh_r[8'h90])
    else $error("count register read back wrong");
  a_b_off: assert property (!be2 && !$past(be2) |-> !ch_b_out[0])
    else $error("B output active while disabled");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> ch_out == 4'h0 && ch_b_out == 2'h0)
    else $error("outputs not cleared by reset");
  a_high_time: assert property (chg && seen_r[1] && md0 && lv_r |-> run_r == lc_r[3:0] + 6'h01)
    else $error("channel 0 high time wrong");
  a_low_time: assert property (chg && seen_r[1] && md0 && !lv_r |-> run_r == lc_r[7:4] + 6'h01)
    else $error("channel 0 low time wrong");
  a_sync_align: assert property (eq_r == 3'h6 |-> ch_out[0] == ch_out[1])
    else $error("equal channels not aligned after sync");
endmodule
bind ccd_top ccd_asserts #(.ADDR_W(ADDR_W)) ccd_asserts_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .ext_clk_in(ext_clk_in), .src_is_vco(src_is_vco), .vco_div_used(vco_div_used), .ch_out(ch_out), .ch_b_out(ch_b_out));
`default_nettype wire

// ---- testbench/ccd_tb_top.sv ----
// Purpose: Self-checking bench for ccd_top
// Assumes: 125 MHz clk, sync reset held 16 cycles
// Notes: Periods taken between rising edges
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; $display("mismatch t=%0t got %0h exp %0h", $time, a, e); end end
module ccd_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic ext_clk_in = 1'b0;
  logic src_is_vco = 1'b1;
  logic vco_div_used = 1'b0;
  wire pready;
  wire pslverr;
  wire [31:0] prdata;
  wire [3:0] ch_out;
  wire [1:0] ch_b_out;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int rt [4];
  int pr [4];
  logic [3:0] lv = 4'h0;
  logic [2:0] eph = 3'h0;
  logic [31:0] rd;
  logic er;
  logic [31:0] seed = 32'h00007669;
  logic [11:0] ix_t [14] = '{12'h190, 12'h191, 12'h192, 12'h196, 12'h197, 12'h198, 12'h199,
    12'h19b, 12'h19c, 12'h19d, 12'h19e, 12'h1a0, 12'h1a1, 12'h1a2};
  logic [4:0] ph_t [7] = '{5'h01, 5'h06, 5'h0b, 5'h10, 5'h15, 5'h1a, 5'h1f};
  ccd_top #(.ADDR_W(14)) ccd_top_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .ext_clk_in(ext_clk_in),
    .src_is_vco(src_is_vco), .vco_div_used(vco_div_used), .ch_out(ch_out), .ch_b_out(ch_b_out));
  // Clock
  initial begin
    forever #4 clk = ~clk;
  end
  // -----------------------------------------
  // Timeout, external clock, rise time record
  // -----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    eph <= eph + 3'h1;
    ext_clk_in <= eph[1];
    lv <= ch_out;
    for (int i = 0; i < 4; i++) begin
      if (ch_out[i] === 1'b1 && lv[i] === 1'b0) begin
        pr[i] <= rt[i];
        rt[i] <= cyc;
      end
    end
    if (cyc == 40000) begin
      n_fail++;
      close_out;
    end
  end
  task automatic close_out;
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int ratio(input logic [7:0] c);
    return int'(c[7:4]) + int'(c[3:0]) + 2;
  endfunction
  function automatic int pdly(input logic [4:0] ph, input logic [3:0] m);
    return ph < 5'h10 ? int'(ph) : int'(ph) - 16 + int'(m) + 1;
  endfunction
  function automatic int ofs();
    return ((rt[0] - rt[1]) % 16 + 16) % 16;
  endfunction
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] ix, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] ix, input logic [7:0] d);
    apb(1'b1, ix, d);
  endtask
  task automatic rchk(input logic [11:0] ix, input logic [7:0] e);
    apb(1'b0, ix, 8'h00);
    `CHK(rd, {24'h000000, e})
  endtask
  task automatic sync_wait(input int n);
    wr(12'h1e2, 8'h01);
    repeat (n) @(posedge clk);
  endtask
  // Channels 0 and 1: counts, phases, duty fix off
  task automatic cfg01(input logic [7:0] c, input logic [7:0] p0, input logic [7:0] p1);
    wr(12'h190, c);
    wr(12'h196, c);
    wr(12'h191, p0);
    wr(12'h197, p1);
    wr(12'h192, 8'h01);
    wr(12'h198, 8'h01);
  endtask
  // Main sequence
  initial begin
    logic [7:0] v;
    int e;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    `CHK(ch_b_out, 2'h0)
    foreach (ix_t[i]) rchk(ix_t[i], 8'h00);
    foreach (ix_t[i]) begin
      seed = nx(seed);
      wr(ix_t[i], seed[7:0]);
      rchk(ix_t[i], seed[7:0]);
    end
    wr(12'h000, 8'h5a);
    apb(1'b0, 12'h000, 8'h00);
    `CHK({er, rd}, 33'h100000000)
    for (int i = 0; i < 8; i++) begin
      seed = nx(seed);
      v = i == 0 ? 8'hff : i == 1 ? 8'h00 : seed[7:0];
      cfg01(v, 8'h00, 8'h00);
      sync_wait(3 * ratio(v) + 20);
      `CHK(rt[0] - pr[0], ratio(v))
      `CHK(rt[1], rt[0])
    end
    foreach (ph_t[i]) begin
      cfg01(8'h77, {3'h0, ph_t[i]}, 8'h00);
      sync_wait(80);
      e = pdly(ph_t[i], 4'h7) % 16;
      `CHK(ofs(), e)
    end
    wr(12'h191, 8'h05);
    repeat (80) @(posedge clk);
    `CHK(ofs(), e)
    for (int i = 0; i < 4; i++) begin
      seed = nx(seed);
      e = ratio({2{seed[3:0]}}) * (i[0] ? 1 : ratio({2{seed[7:4]}}));
      for (int j = 0; j < 2; j++) begin
        wr(j ? 12'h19e : 12'h199, {2{seed[3:0]}});
        wr(j ? 12'h1a0 : 12'h19b, {2{seed[7:4]}});
        wr(j ? 12'h1a1 : 12'h19c, {1'b0, i[1], i[0], 5'h00});
        wr(j ? 12'h1a2 : 12'h19d, 8'h00);
      end
      sync_wait(3 * e + 40);
      `CHK(rt[2] - pr[2], e)
      `CHK(rt[3] - pr[3], e)
    end
    src_is_vco <= 1'b0;
    cfg01(8'h10, 8'h00, 8'h00);
    sync_wait(80);
    `CHK(rt[0] - pr[0], 12)
    src_is_vco <= 1'b1;
    vco_div_used <= 1'b1;
    for (int d = 2; d < 7; d++) begin
      wr(12'h1e0, d[7:0]);
      sync_wait(80);
      `CHK(rt[0] - pr[0], 3 * d)
    end
    close_out;
  end
endmodule
`default_nettype wire
